// >>> rtl/pag_address_gen.sv
`default_nettype none
module pag_address_gen #(
  parameter int ADDR_W = pag_pkg::ADDR_WIDTH,
  parameter int RPT_W  = pag_pkg::RPT_WIDTH
) (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic                holdReq,
  input  wire logic                reqValid,
  input  wire pag_pkg::pag_req_type req,
  output logic                     reqReady,
  output logic      [ADDR_W-1:0]   programAddressBus,
  output logic      [ADDR_W-1:0]   programCounter,
  output logic      [ADDR_W-1:0]   stackTop,
  output logic      [ADDR_W-1:0]   accLowOut,
  output logic                     accLowLoad,
  output logic      [ADDR_W-1:0]   dataWriteWord,
  output logic                     dataWriteStrobe,
  output logic      [RPT_W-1:0]    repeatCounter,
  output logic                     repeatActive,
  output logic                     blockBusy
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    pag_pkg::pag_state_type fsm;
    logic [ADDR_W-1:0]      pc;
    logic [ADDR_W-1:0]      addrLatch;
    logic [ADDR_W-1:0]      microStore;
    logic [RPT_W-1:0]       rptCount;
    logic                   rptArmed;
    logic                   started;
    logic [ADDR_W-1:0]      accOut;
    logic                   accLoad;
    logic [ADDR_W-1:0]      dataOut;
    logic                   dataStb;
  } pag_state_type_all_type;

  pag_state_type_all_type state_r;
  pag_state_type_all_type state_nxt;

  logic              stkPush;
  logic              stkPop;
  logic [ADDR_W-1:0] stkPushData;
  logic              take;
  logic [ADDR_W-1:0] stepSize;
  logic [ADDR_W-1:0] nextSeq;

  // ****************************************************************
  // return stack
  // ****************************************************************
  pag_return_stack #(
    .DEPTH (pag_pkg::STACK_DEPTH),
    .WIDTH (ADDR_W)
  ) u_stack (
    .core_clk (core_clk),
    .reset    (reset),
    .push     (stkPush),
    .pop      (stkPop),
    .pushData (stkPushData),
    .stackTop (stackTop)
  );

  // accept requests only once reset and hold are both gone
  assign take = reqValid && reqReady;
  assign reqReady = state_r.started && !holdReq;

  // step size for the sequential flow
  assign stepSize = req.twoWord ? pag_pkg::STEP_TWO : pag_pkg::STEP_ONE;
  assign nextSeq  = state_r.pc + stepSize;

  // ****************************************************************
  // stack control, no overflow flag exists
  // ****************************************************************
  always_comb begin
    stkPush     = 1'b0;
    stkPop      = 1'b0;
    stkPushData = nextSeq;
    if (take && state_r.fsm == pag_pkg::PAG_ST_RUN) begin
      case (req.op)
        pag_pkg::PAG_OP_CALL,
        pag_pkg::PAG_OP_CALLACC,
        pag_pkg::PAG_OP_INTR: begin
          stkPush     = 1'b1;
          stkPushData = (req.op == pag_pkg::PAG_OP_INTR) ? state_r.pc
                                                         : nextSeq;
        end
        pag_pkg::PAG_OP_PUSHACC: begin
          stkPush     = 1'b1;
          stkPushData = req.accLow;
        end
        pag_pkg::PAG_OP_PUSHDATA: begin
          stkPush     = 1'b1;
          stkPushData = req.dataWord;
        end
        pag_pkg::PAG_OP_RETURN,
        pag_pkg::PAG_OP_POPACC,
        pag_pkg::PAG_OP_POPDATA: begin
          stkPop = 1'b1;
        end
        default: begin
          stkPush = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_nxt         = state_r;
    state_nxt.accLoad = 1'b0;
    state_nxt.dataStb = 1'b0;
    // fetch starts once hold drops after reset
    if (!state_r.started && !holdReq) begin
      state_nxt.started   = 1'b1;
      state_nxt.pc        = pag_pkg::RESET_ADDR;
      state_nxt.addrLatch = pag_pkg::RESET_ADDR;
    end
    if (take) begin
      case (state_r.fsm)
        pag_pkg::PAG_ST_RUN: begin
          case (req.op)
            pag_pkg::PAG_OP_SEQ: begin
              state_nxt.addrLatch = state_r.pc;
              state_nxt.pc        = nextSeq;
              if (state_r.rptArmed) begin
                state_nxt.rptArmed = 1'b0;
              end
            end
            pag_pkg::PAG_OP_BRANCH,
            pag_pkg::PAG_OP_CALL: begin
              state_nxt.addrLatch = req.operand;
              state_nxt.pc        = req.operand + pag_pkg::STEP_ONE;
            end
            pag_pkg::PAG_OP_INTR: begin
              state_nxt.addrLatch = req.operand;
              state_nxt.pc        = req.operand + pag_pkg::STEP_ONE;
            end
            pag_pkg::PAG_OP_BRACC,
            pag_pkg::PAG_OP_CALLACC: begin
              state_nxt.addrLatch = req.accLow;
              state_nxt.pc        = req.accLow + pag_pkg::STEP_ONE;
            end
            pag_pkg::PAG_OP_RETURN: begin
              state_nxt.addrLatch = stackTop;
              state_nxt.pc        = stackTop + pag_pkg::STEP_ONE;
            end
            pag_pkg::PAG_OP_POPACC: begin
              state_nxt.accOut  = stackTop;
              state_nxt.accLoad = 1'b1;
            end
            pag_pkg::PAG_OP_POPDATA: begin
              state_nxt.dataOut = stackTop;
              state_nxt.dataStb = 1'b1;
            end
            pag_pkg::PAG_OP_RPTLOAD: begin
              state_nxt.rptCount = req.operand;
              state_nxt.rptArmed = 1'b1;
            end
            pag_pkg::PAG_OP_BLKSTART: begin
              // save next fetch, then drive first operand address
              state_nxt.microStore = nextSeq;
              state_nxt.addrLatch  = req.operand;
              state_nxt.pc         = req.operand + pag_pkg::STEP_ONE;
              state_nxt.fsm        = pag_pkg::PAG_ST_BLOCK;
            end
            pag_pkg::PAG_OP_DUMMY: begin
              state_nxt.addrLatch = state_r.addrLatch;
            end
            default: begin
              state_nxt.pc = state_r.pc;
            end
          endcase
        end
        pag_pkg::PAG_ST_BLOCK: begin
          if (state_r.rptCount != pag_pkg::ZERO_WORD) begin
            // each repeat steps the first operand address
            state_nxt.addrLatch = state_r.pc;
            state_nxt.pc        = state_r.pc + pag_pkg::STEP_ONE;
            state_nxt.rptCount  = state_r.rptCount - pag_pkg::STEP_ONE;
          end else begin
            // done: restore saved fetch address from micro store
            state_nxt.addrLatch = state_r.microStore;
            state_nxt.pc        = state_r.microStore
                                  + pag_pkg::STEP_ONE;
            state_nxt.rptArmed  = 1'b0;
            state_nxt.fsm       = pag_pkg::PAG_ST_RUN;
          end
        end
        default: begin
          state_nxt.fsm = pag_pkg::PAG_ST_RUN;
        end
      endcase
    end
  end

  // register the state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r.fsm        <= pag_pkg::PAG_ST_RUN;
      state_r.pc         <= pag_pkg::RESET_ADDR;
      state_r.addrLatch  <= pag_pkg::RESET_ADDR;
      state_r.microStore <= pag_pkg::ZERO_WORD;
      state_r.rptCount   <= pag_pkg::ZERO_WORD;
      state_r.rptArmed   <= 1'b0;
      state_r.started    <= 1'b0;
      state_r.accOut     <= pag_pkg::ZERO_WORD;
      state_r.accLoad    <= 1'b0;
      state_r.dataOut    <= pag_pkg::ZERO_WORD;
      state_r.dataStb    <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign programAddressBus = state_r.addrLatch;
  assign programCounter    = state_r.pc;
  assign accLowOut         = state_r.accOut;
  assign accLowLoad        = state_r.accLoad;
  assign dataWriteWord     = state_r.dataOut;
  assign dataWriteStrobe   = state_r.dataStb;
  assign repeatCounter     = state_r.rptCount;
  assign repeatActive      = state_r.rptArmed;
  assign blockBusy         = (state_r.fsm == pag_pkg::PAG_ST_BLOCK);

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_seq_step: assert property (
    @(posedge core_clk) disable iff (reset)
    (take && state_r.fsm == pag_pkg::PAG_ST_RUN
     && req.op == pag_pkg::PAG_OP_SEQ)
    |=> programCounter == $past(state_r.pc) + $past(stepSize))
    else $error("sequential step wrong");

  a_seq_latch: assert property (
    @(posedge core_clk) disable iff (reset)
    (take && state_r.fsm == pag_pkg::PAG_ST_RUN
     && req.op == pag_pkg::PAG_OP_SEQ)
    |=> programAddressBus == $past(state_r.pc))
    else $error("latch not at fetched address");

  a_branch_load: assert property (
    @(posedge core_clk) disable iff (reset)
    (take && state_r.fsm == pag_pkg::PAG_ST_RUN
     && req.op == pag_pkg::PAG_OP_BRANCH)
    |=> programAddressBus == $past(req.operand))
    else $error("branch target not loaded");

  a_call_push: assert property (
    @(posedge core_clk) disable iff (reset)
    (take && state_r.fsm == pag_pkg::PAG_ST_RUN
     && req.op == pag_pkg::PAG_OP_CALL)
    |=> stackTop == $past(nextSeq) && programAddressBus == $past(req.operand))
    else $error("call did not push return address");

  a_acc_branch: assert property (
    @(posedge core_clk) disable iff (reset)
    (take && state_r.fsm == pag_pkg::PAG_ST_RUN
     && req.op == pag_pkg::PAG_OP_BRACC)
    |=> programAddressBus == $past(req.accLow))
    else $error("accumulator branch wrong");

  a_acc_pop: assert property (
    @(posedge core_clk) disable iff (reset)
    (take && state_r.fsm == pag_pkg::PAG_ST_RUN
     && req.op == pag_pkg::PAG_OP_POPACC)
    |=> accLowLoad && accLowOut == $past(stackTop)
        ##1 (!accLowLoad
             || $past(stkPop && req.op == pag_pkg::PAG_OP_POPACC)))
    else $error("accumulator pop wrong");

  a_data_pop: assert property (
    @(posedge core_clk) disable iff (reset)
    (take && state_r.fsm == pag_pkg::PAG_ST_RUN
     && req.op == pag_pkg::PAG_OP_POPDATA)
    |=> dataWriteStrobe && dataWriteWord == $past(stackTop))
    else $error("data pop wrong");

  a_micro_restore: assert property (
    @(posedge core_clk) disable iff (reset)
    (take && blockBusy && repeatCounter == pag_pkg::ZERO_WORD)
    |=> !blockBusy && programAddressBus == $past(state_r.microStore))
    else $error("micro store not restored");

  a_reset_start: assert property (@(posedge core_clk)
    $fell(reset) |-> programAddressBus == pag_pkg::RESET_ADDR && !reqReady)
    else $error("fetch not started at zero");

  a_intr_push: assert property (
    @(posedge core_clk) disable iff (reset)
    (take && state_r.fsm == pag_pkg::PAG_ST_RUN
     && req.op == pag_pkg::PAG_OP_INTR)
    |=> stackTop == $past(state_r.pc)
        && programAddressBus == $past(req.operand))
    else $error("interrupt vector not taken");

  a_ret_pop: assert property (
    @(posedge core_clk) disable iff (reset)
    (take && state_r.fsm == pag_pkg::PAG_ST_RUN
     && req.op == pag_pkg::PAG_OP_RETURN)
    |=> programAddressBus == $past(stackTop))
    else $error("return address not popped");

  a_blk_save: assert property (
    @(posedge core_clk) disable iff (reset)
    (take && state_r.fsm == pag_pkg::PAG_ST_RUN
     && req.op == pag_pkg::PAG_OP_BLKSTART)
    |=> blockBusy && state_r.microStore == $past(nextSeq))
    else $error("micro store not saved");

  a_blk_step: assert property (
    @(posedge core_clk) disable iff (reset)
    (take && blockBusy && repeatCounter != pag_pkg::ZERO_WORD)
    |=> blockBusy && programAddressBus == $past(programCounter)
        && repeatCounter == $past(repeatCounter) - pag_pkg::STEP_ONE)
    else $error("repeat step wrong");

  a_dummy_hold: assert property (
    @(posedge core_clk) disable iff (reset)
    (take && state_r.fsm == pag_pkg::PAG_ST_RUN
     && req.op == pag_pkg::PAG_OP_DUMMY)
    |=> $stable(programAddressBus) && $stable(programCounter))
    else $error("dummy cycle moved the address");

  a_hold_freeze: assert property (
    @(posedge core_clk) disable iff (reset)
    holdReq |=> $stable(programCounter) && $stable(programAddressBus))
    else $error("address moved during hold");

endmodule : pag_address_gen
`default_nettype wire

// >>> common/pag_pkg.sv
`default_nettype none
package pag_pkg;

  // ****************************************************************
  // widths and depths
  // ****************************************************************
  localparam int ADDR_WIDTH  = 16;
  localparam int STACK_DEPTH = 8;
  localparam int RPT_WIDTH   = 16;

  // ****************************************************************
  // reset values and step sizes
  // ****************************************************************
  localparam logic [15:0] RESET_ADDR = 16'h0000;
  localparam logic [15:0] ZERO_WORD  = 16'h0000;
  localparam logic [15:0] STEP_ONE   = 16'h0001;
  localparam logic [15:0] STEP_TWO   = 16'h0002;

  // ****************************************************************
  // operation codes of the address generator
  // ****************************************************************
  typedef enum logic [3:0] {
    PAG_OP_NONE     = 4'h0, // hold
    PAG_OP_SEQ      = 4'h1, // sequential step
    PAG_OP_BRANCH   = 4'h2, // immediate branch
    PAG_OP_CALL     = 4'h3, // immediate call
    PAG_OP_RETURN   = 4'h4, // return via stack top
    PAG_OP_INTR     = 4'h5, // interrupt vector
    PAG_OP_BRACC    = 4'h6, // branch_to_accumulator
    PAG_OP_CALLACC  = 4'h7, // call_via_accumulator
    PAG_OP_PUSHACC  = 4'h8, // accumulator push
    PAG_OP_POPACC   = 4'h9, // accumulator pop
    PAG_OP_PUSHDATA = 4'ha, // push_data_word
    PAG_OP_POPDATA  = 4'hb, // pop_to_data_word
    PAG_OP_BLKSTART = 4'hc, // start block/table/mac instruction
    PAG_OP_RPTLOAD  = 4'hd, // repeat_instruction load
    PAG_OP_DUMMY    = 4'he  // dummy cycle
  } pag_op_type;

  // ****************************************************************
  // request carrier
  // ****************************************************************
  typedef struct packed {
    pag_op_type  op;
    logic        twoWord;  // current instruction has two words
    logic [15:0] operand;  // program_read_bus word or vector address
    logic [15:0] accLow;   // data_read_bus accumulator low half
    logic [15:0] dataWord; // data word for push_data_word
  } pag_req_type;

  // ****************************************************************
  // fsm of the block sequencer
  // ****************************************************************
  typedef enum logic [1:0] {
    PAG_ST_RUN   = 2'b00,
    PAG_ST_BLOCK = 2'b01
  } pag_state_type;

endpackage : pag_pkg
`default_nettype wire

// >>> rtl/pag_return_stack.sv
`default_nettype none
module pag_return_stack #(
  parameter int DEPTH = pag_pkg::STACK_DEPTH,
  parameter int WIDTH = pag_pkg::ADDR_WIDTH
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] pushData,
  output logic      [WIDTH-1:0] stackTop
);

  // ****************************************************************
  // storage
  // ****************************************************************
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] level;
  } pag_stk_state_type;

  pag_stk_state_type state_r;
  pag_stk_state_type state_nxt;

  // shift down on push, up on pop, bottom kept on pop
  always_comb begin
    state_nxt = state_r;
    if (push) begin
      state_nxt.level[0] = pushData;
      for (int i = 1; i < DEPTH; i++) begin
        state_nxt.level[i] = state_r.level[i-1];
      end
    end else if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        state_nxt.level[i] = state_r.level[i+1];
      end
    end
  end

  // register the stack
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign stackTop = state_r.level[0];

  a_push_shift: assert property (
    @(posedge core_clk) disable iff (reset)
    push |=> state_r.level[DEPTH-1] == $past(state_r.level[DEPTH-2]))
    else $error("push did not shift stack down");

  a_pop_bottom: assert property (
    @(posedge core_clk) disable iff (reset)
    (pop && !push) |=> state_r.level[DEPTH-1] == $past(state_r.level[DEPTH-1])
      && state_r.level[DEPTH-2] == $past(state_r.level[DEPTH-1]))
    else $error("pop did not keep bottom entry");

endmodule : pag_return_stack
`default_nettype wire

// >>> testbench/pag_prog_mem.sv
`default_nettype none
// ****************************************************************
// program memory seen across the program address bus
// ****************************************************************
module pag_prog_mem (
  input  wire logic [15:0] programAddressBus,
  output logic      [15:0] programReadBus
);
  timeunit 1ns;
  timeprecision 1ps;
  // word content follows the low address byte, so fetches 256 words apart read alike
  always_comb begin
    programReadBus = {programAddressBus[7:0] ^ 8'h3c, 8'h10};
  end
endmodule : pag_prog_mem
`default_nettype wire

// >>> testbench/testbench.sv
`default_nettype none
// ****************************************************************
// bench for the program address generator
// ****************************************************************
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 core_clk;
  logic                 reset;
  logic                 holdReq;
  logic                 reqValid;
  pag_pkg::pag_req_type req;
  logic                 reqReady;
  logic [15:0]          programAddressBus;
  logic [15:0]          programCounter;
  logic [15:0]          stackTop;
  logic [15:0]          accLowOut;
  logic                 accLowLoad;
  logic [15:0]          dataWriteWord;
  logic                 dataWriteStrobe;
  logic [15:0]          repeatCounter;
  logic                 repeatActive;
  logic                 blockBusy;
  logic [15:0]          programReadBus;
  logic [15:0]          expPc;
  logic [15:0]          tgt;
  int                   fails;
  int                   cmpCount;
  int                   cycles;

  pag_address_gen pag_address_gen_i (
    .core_clk          (core_clk),
    .reset             (reset),
    .holdReq           (holdReq),
    .reqValid          (reqValid),
    .req               (req),
    .reqReady          (reqReady),
    .programAddressBus (programAddressBus),
    .programCounter    (programCounter),
    .stackTop          (stackTop),
    .accLowOut         (accLowOut),
    .accLowLoad        (accLowLoad),
    .dataWriteWord     (dataWriteWord),
    .dataWriteStrobe   (dataWriteStrobe),
    .repeatCounter     (repeatCounter),
    .repeatActive      (repeatActive),
    .blockBusy         (blockBusy)
  );
  pag_prog_mem pag_prog_mem_i (
    .programAddressBus (programAddressBus),
    .programReadBus    (programReadBus)
  );

  // clock and hang guard
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 3000) begin
      fails++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one request held until taken, then settled outputs at negedge
  task automatic send(input pag_pkg::pag_op_type op, input logic tw,
                      input logic [15:0] opd, input logic [15:0] acc,
                      input logic [15:0] dw);
    logic rdy;
    int   n;
    rdy = 1'b0;
    n = 0;
    @(posedge core_clk);
    reqValid <= 1'b1;
    req      <= '{op, tw, opd, acc, dw};
    while (rdy !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      rdy = reqReady;
      @(posedge core_clk);
      n++;
    end
    reqValid <= 1'b0;
    chk({15'h0000, rdy}, 16'h0001);
    @(negedge core_clk);
  endtask : send

  task automatic s_flow();
    send(pag_pkg::PAG_OP_SEQ, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    chk(programAddressBus, 16'h0000);
    chk(programCounter, 16'h0001);
    send(pag_pkg::PAG_OP_SEQ, 1'b1, 16'h0000, 16'h0000, 16'h0000);
    chk(programAddressBus, 16'h0001);
    chk(programCounter, 16'h0003);
    tgt = programReadBus;
    send(pag_pkg::PAG_OP_BRANCH, 1'b1, tgt, 16'h0000, 16'h0000);
    chk(programAddressBus, tgt);
    chk(programCounter, tgt + 16'h0001);
    expPc = tgt + 16'h0001;
  endtask : s_flow

  task automatic s_call();
    send(pag_pkg::PAG_OP_CALL, 1'b1, 16'h4000, 16'h0000, 16'h0000);
    chk(stackTop, expPc + 16'h0002);
    chk(programAddressBus, 16'h4000);
    send(pag_pkg::PAG_OP_RETURN, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    chk(programAddressBus, expPc + 16'h0002);
    chk(programCounter, expPc + 16'h0003);
    expPc = expPc + 16'h0003;
    send(pag_pkg::PAG_OP_INTR, 1'b0, 16'h0004, 16'h0000, 16'h0000);
    chk(stackTop, expPc);
    chk(programAddressBus, 16'h0004);
    send(pag_pkg::PAG_OP_RETURN, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    chk(programAddressBus, expPc);
    send(pag_pkg::PAG_OP_BRACC, 1'b0, 16'h0000, 16'h5a5a, 16'h0000);
    chk(programCounter, 16'h5a5b);
    send(pag_pkg::PAG_OP_CALLACC, 1'b0, 16'h0000, 16'h0abc, 16'h0000);
    chk(stackTop, 16'h5a5c);
    chk(programAddressBus, 16'h0abc);
    send(pag_pkg::PAG_OP_RETURN, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    chk(programCounter, 16'h5a5d);
    send(pag_pkg::PAG_OP_DUMMY, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    chk(programAddressBus, 16'h5a5c);
    chk(programCounter, 16'h5a5d);
    send(pag_pkg::PAG_OP_NONE, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    chk(programCounter, 16'h5a5d);
    expPc = 16'h5a5d;
  endtask : s_call

  // nine pushes overflow, pops then run down to the bottom copy
  task automatic s_stack();
    logic [15:0] v;
    for (int i = 1; i <= 9; i++) begin
      send(pag_pkg::PAG_OP_PUSHACC, 1'b0, 16'h0000, 16'(i), 16'h0000);
      chk(stackTop, 16'(i));
    end
    for (int k = 0; k < 10; k++) begin
      v = (k < 8) ? 16'(9 - k) : 16'h0002;
      send(pag_pkg::PAG_OP_POPACC, 1'b0, 16'h0000, 16'h0000, 16'h0000);
      chk(accLowOut, v);
      chk({15'h0000, accLowLoad}, 16'h0001);
    end
    chk(stackTop, 16'h0002);
    @(negedge core_clk);
    chk({15'h0000, accLowLoad}, 16'h0000);
    send(pag_pkg::PAG_OP_PUSHDATA, 1'b0, 16'h0000, 16'h0000, 16'hbeef);
    chk(stackTop, 16'hbeef);
    send(pag_pkg::PAG_OP_POPDATA, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    chk(dataWriteWord, 16'hbeef);
    chk({15'h0000, dataWriteStrobe}, 16'h0001);
    @(negedge core_clk);
    chk({15'h0000, dataWriteStrobe}, 16'h0000);
    chk(programCounter, expPc);
  endtask : s_stack

  // repeated block move steps the operand, then restores the fetch
  task automatic s_block();
    send(pag_pkg::PAG_OP_RPTLOAD, 1'b0, 16'h0002, 16'h0000, 16'h0000);
    chk(repeatCounter, 16'h0002);
    chk({15'h0000, repeatActive}, 16'h0001);
    send(pag_pkg::PAG_OP_BLKSTART, 1'b1, 16'h0300, 16'h0000, 16'h0000);
    chk(programAddressBus, 16'h0300);
    chk({15'h0000, blockBusy}, 16'h0001);
    for (int s = 1; s <= 2; s++) begin
      send(pag_pkg::PAG_OP_SEQ, 1'b0, 16'h0000, 16'h0000, 16'h0000);
      chk(programAddressBus, 16'h0300 + 16'(s));
      chk(repeatCounter, 16'(2 - s));
    end
    send(pag_pkg::PAG_OP_SEQ, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    chk(programAddressBus, expPc + 16'h0002);
    chk(programCounter, expPc + 16'h0003);
    chk({15'h0000, blockBusy}, 16'h0000);
    chk({15'h0000, repeatActive}, 16'h0000);
    expPc = expPc + 16'h0003;
  endtask : s_block

  // a request waits out the hold, nothing moves meanwhile
  task automatic s_hold();
    send(pag_pkg::PAG_OP_RPTLOAD, 1'b0, 16'h0005, 16'h0000, 16'h0000);
    chk({15'h0000, repeatActive}, 16'h0001);
    @(posedge core_clk);
    holdReq  <= 1'b1;
    reqValid <= 1'b1;
    req      <= '{pag_pkg::PAG_OP_SEQ, 1'b0, 16'h0000, 16'h0000, 16'h0000};
    repeat (3) begin
      @(negedge core_clk);
      chk({15'h0000, reqReady}, 16'h0000);
      chk(programCounter, expPc);
    end
    @(posedge core_clk);
    holdReq <= 1'b0;
    @(negedge core_clk);
    chk({15'h0000, reqReady}, 16'h0001);
    @(posedge core_clk);
    reqValid <= 1'b0;
    @(negedge core_clk);
    chk(programAddressBus, expPc);
    chk(programCounter, expPc + 16'h0001);
    chk({15'h0000, repeatActive}, 16'h0000);
  endtask : s_hold

  // reset in mid-run with hold outlasting it
  task automatic s_reset();
    @(posedge core_clk);
    reset   <= 1'b1;
    holdReq <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk({15'h0000, reqReady}, 16'h0000);
    chk(programCounter, 16'h0000);
    chk({15'h0000, blockBusy}, 16'h0000);
    @(posedge core_clk);
    holdReq <= 1'b0;
    @(negedge core_clk);
    send(pag_pkg::PAG_OP_SEQ, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    chk(programAddressBus, 16'h0000);
    chk(programCounter, 16'h0001);
  endtask : s_reset

  // main sequence
  initial begin
    reset    = 1'b1;
    holdReq  = 1'b0;
    reqValid = 1'b0;
    req      = '0;
    fails    = 0;
    cmpCount = 0;
    cycles   = 0;
    expPc    = 16'h0000;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chk(stackTop, 16'h0000);
    s_flow();
    s_call();
    s_stack();
    s_block();
    s_hold();
    s_reset();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
